// ==== shared/ppq_pkg.sv ====
// Package for the priority packet queue: sizes, priorities, framing constants.
// Assumes one system clock and an asynchronous power-up reset.
`default_nettype none
package ppq_pkg;
   localparam int PKT_W         = 32;
   localparam int PRIO_W        = 4;
   localparam int SLOTS         = 2000;
   localparam int EVENT_SLOTS   = 200;
   localparam int EVENT_COST    = SLOTS / EVENT_SLOTS;
   localparam int REPORT_COST   = 1;
   localparam int IDX_W         = 11;
   localparam int COST_W        = 12;
   localparam int FIFO_DEPTH    = 8;
   localparam int ASSET_ID_BYTES = 3;
   localparam int UDP_IP_BYTES  = 28;
   localparam logic [3:0] PRIO_RESET    = 4'h0;
   localparam logic [3:0] PRIO_SETTINGS = 4'h1;
   localparam logic [3:0] PRIO_POLL     = 4'h2;
   localparam logic [3:0] PRIO_POWER    = 4'h3;
   localparam logic [3:0] PRIO_WAYPOINT = 4'h4;
   localparam logic [3:0] PRIO_STATUS   = 4'h5;
   localparam logic [3:0] PRIO_TRANSP   = 4'h6;
   localparam logic [3:0] PRIO_POS      = 4'h7;
   localparam logic [3:0] PRIO_POS_TERR = 4'h8;
   localparam logic [3:0] PRIO_SERVER   = 4'hA;
   localparam logic [1:0] NET_NONE = 2'h0;
   localparam logic [1:0] NET_CELL = 2'h1;
   localparam logic [1:0] NET_RF   = 2'h2;
   localparam logic [1:0] NET_SAT  = 2'h3;
   typedef enum logic [2:0] {
      PPQ_SCAN  = 3'b000,
      PPQ_PDOWN = 3'b001,
      PPQ_PUP   = 3'b011,
      PPQ_IDLE  = 3'b010,
      PPQ_EVICT = 3'b110,
      PPQ_SEND  = 3'b111
   } ppq_state_e;
endpackage : ppq_pkg
`default_nettype wire

// ==== design/ppq_fifo.sv ====
// Parameterised valid/ready FIFO.
// Assumes both sides on one clock.
`default_nettype none
module ppq_fifo #(
   parameter int W = 32,
   parameter int D = 8
) (
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic [W-1:0] in_data_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   output logic [W-1:0]      out_data_out,
   output logic              out_valid_out,
   input  wire logic         out_ready_in
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   wire push = in_valid_in && in_ready_out;
   wire pop  = out_valid_out && out_ready_in;
   assign in_ready_out  = count != (AW+1)'(D);
   assign out_valid_out = count != '0;
   assign out_data_out  = mem[rd_ptr];
   always_ff @(posedge clk_in)
   begin
      if (push) mem[wr_ptr] <= in_data_in;
   end
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push) wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)  rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ppq_fifo
`default_nettype wire

// ==== design/ppq_queue.sv ====
// Priority packet queue with power-up rebuild, eviction and modem drain.
// Assumes producers on clk_in; backed memory image supplied on the scan ports.
// Function
// - Holds 200 events or 2000 reports
// - Full: evict oldest equal-or-lower priority packets
// - Priority 0 reset highest, 10 server lowest
// - Power up rescans memory, re-queues valid packets
// - Power up queues power-down and power-up events
// - First transmission carries device-reset packet
// - No network or buffering: hold packets
// - Asset ID prefix on RF and cellular; cellular adds UDP/IP; satellite has none
`default_nettype none
module ppq_queue #(
   parameter int SLOTS = ppq_pkg::SLOTS,
   parameter int W     = ppq_pkg::PKT_W
) (
   input  wire logic                        clk_in,
   input  wire logic                        sys_rst_in,
   input  wire logic                        pwr_events_en_in,
   input  wire logic [W-1:0]                last_sat_time_in,
   input  wire logic [W-1:0]                rtc_time_in,
   input  wire logic                        scan_valid_in,
   input  wire logic                        scan_done_in,
   input  wire logic [W-1:0]                scan_data_in,
   input  wire logic [ppq_pkg::PRIO_W-1:0]  scan_prio_in,
   input  wire logic                        scan_event_in,
   output logic                             scan_ready_out,
   input  wire logic                        new_valid_in,
   input  wire logic [W-1:0]                new_data_in,
   input  wire logic [ppq_pkg::PRIO_W-1:0]  new_prio_in,
   input  wire logic                        new_event_in,
   output logic                             new_ready_out,
   output logic                             new_dropped_out,
   input  wire logic [1:0]                  net_in,
   input  wire logic                        buffer_net_in,
   output logic [W-1:0]                     tx_data_out,
   output logic [ppq_pkg::PRIO_W-1:0]       tx_prio_out,
   output logic [5:0]                       tx_overhead_out,
   output logic                             tx_valid_out,
   input  wire logic                        tx_ready_in,
   output logic [ppq_pkg::COST_W-1:0]       used_out
);
   localparam int IW = ppq_pkg::IDX_W;
   localparam int CW = ppq_pkg::COST_W;
   localparam int PW = ppq_pkg::PRIO_W;
   localparam logic [CW-1:0] CAP = CW'(SLOTS);

   // Circular store, oldest at head
   logic [W-1:0]  data_mem [SLOTS];
   logic [PW-1:0] prio_mem [SLOTS];
   logic          evt_mem  [SLOTS];
   logic          live_mem [SLOTS];
   logic [IW-1:0] head;
   logic [IW-1:0] tail;
   logic [IW-1:0] cnt;
   logic [IW-1:0] probe;
   logic [CW-1:0] used;
   logic [CW-1:0] evict_acc;
   logic          first_tx;
   logic          pwr_done;
   ppq_pkg::ppq_state_e state;

   // Pending insert
   logic          ins_go;
   logic [W-1:0]  ins_data;
   logic [PW-1:0] ins_prio;
   logic          ins_evt;

   wire [CW-1:0] ins_cost  = ins_evt ? CW'(ppq_pkg::EVENT_COST) : CW'(ppq_pkg::REPORT_COST);
   wire [CW-1:0] free      = CAP - used;
   wire          fits      = ins_cost <= free;
   wire [CW-1:0] probe_cost = evt_mem[probe] ? CW'(ppq_pkg::EVENT_COST) : CW'(ppq_pkg::REPORT_COST);
   wire          probe_hit = live_mem[probe] && (prio_mem[probe] >= ins_prio);
   // Plan total including the entry under the probe this cycle
   wire [CW-1:0] acc_nx     = evict_acc + (probe_hit ? probe_cost : '0);
   wire          fits_after = ins_cost <= (free + acc_nx);
   wire [IW-1:0] probe_nx  = (probe == IW'(SLOTS-1)) ? '0 : probe + 1'b1;
   wire [IW-1:0] tail_nx   = (tail == IW'(SLOTS-1)) ? '0 : tail + 1'b1;
   wire [IW-1:0] head_nx   = (head == IW'(SLOTS-1)) ? '0 : head + 1'b1;
   wire          probe_end = probe_nx == tail;
   wire          net_up    = (net_in != ppq_pkg::NET_NONE) && !buffer_net_in;
   wire          head_live = live_mem[head];
   // Erased entry at head must leave the ring before its index is reused
   wire          reclaim   = (cnt != '0) && !head_live;
   wire          ring_full = cnt == IW'(SLOTS);
   wire          ins_now   = (state == ppq_pkg::PPQ_IDLE) && ins_go && fits && !ring_full && !reclaim;
   wire [5:0]    ovh = (net_in == ppq_pkg::NET_CELL) ? 6'(ppq_pkg::ASSET_ID_BYTES + ppq_pkg::UDP_IP_BYTES)
                     : (net_in == ppq_pkg::NET_RF) ? 6'(ppq_pkg::ASSET_ID_BYTES) : 6'h00;

   // Eviction scan walks oldest first; plan is committed only if it frees enough
   logic          commit;
   always_ff @(posedge clk_in)
   begin
      if (ins_now)
      begin
         data_mem[tail] <= ins_data;
         prio_mem[tail] <= ins_prio;
         evt_mem[tail]  <= ins_evt;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state     <= ppq_pkg::PPQ_SCAN;
         head      <= '0;
         tail      <= '0;
         cnt       <= '0;
         probe     <= '0;
         used      <= '0;
         evict_acc <= '0;
         commit    <= 1'b0;
         first_tx  <= 1'b1;
         ins_go    <= 1'b0;
         ins_data  <= '0;
         ins_prio  <= '0;
         ins_evt   <= 1'b0;
         scan_ready_out  <= 1'b0;
         new_ready_out   <= 1'b0;
         new_dropped_out <= 1'b0;
         tx_data_out     <= '0;
         tx_prio_out     <= '0;
         tx_overhead_out <= '0;
         tx_valid_out    <= 1'b0;
         used_out        <= '0;
      end
      else
      begin
         new_dropped_out <= 1'b0;
         used_out        <= used;
         unique case (state)
            ppq_pkg::PPQ_SCAN:
            begin
               scan_ready_out <= !ins_go;
               if (scan_valid_in && scan_ready_out)
               begin
                  ins_go   <= 1'b1;
                  ins_data <= scan_data_in;
                  ins_prio <= scan_prio_in;
                  ins_evt  <= scan_event_in;
                  scan_ready_out <= 1'b0;
                  state    <= ppq_pkg::PPQ_IDLE;
               end
               else if (scan_done_in && !ins_go)
               begin
                  scan_ready_out <= 1'b0;
                  state <= pwr_events_en_in ? ppq_pkg::PPQ_PDOWN : ppq_pkg::PPQ_IDLE;
               end
            end
            ppq_pkg::PPQ_PDOWN:
            begin
               ins_go   <= 1'b1;
               ins_data <= last_sat_time_in;
               ins_prio <= ppq_pkg::PRIO_POWER;
               ins_evt  <= 1'b1;
               state    <= ppq_pkg::PPQ_IDLE;
               commit   <= 1'b1;
            end
            ppq_pkg::PPQ_PUP:
            begin
               ins_go   <= 1'b1;
               ins_data <= rtc_time_in;
               ins_prio <= ppq_pkg::PRIO_POWER;
               ins_evt  <= 1'b1;
               state    <= ppq_pkg::PPQ_IDLE;
               commit   <= 1'b0;
            end
            ppq_pkg::PPQ_IDLE:
            begin
               if (ins_go && reclaim)
               begin
                  head <= head_nx;
                  cnt  <= cnt - 1'b1;
               end
               else if (ins_now)
               begin
                  live_mem[tail] <= 1'b1;
                  tail   <= tail_nx;
                  cnt    <= cnt + 1'b1;
                  used   <= used + ins_cost;
                  ins_go <= 1'b0;
                  if (commit) state <= ppq_pkg::PPQ_PUP;
                  else if (!pwr_done) state <= ppq_pkg::PPQ_SCAN;
               end
               else if (ins_go)
               begin
                  probe     <= head;
                  evict_acc <= '0;
                  state     <= ppq_pkg::PPQ_EVICT;
               end
               else if (new_valid_in && new_ready_out)
               begin
                  ins_go   <= 1'b1;
                  ins_data <= new_data_in;
                  ins_prio <= new_prio_in;
                  ins_evt  <= new_event_in;
                  new_ready_out <= 1'b0;
               end
               else if (cnt != '0 && !head_live)
               begin
                  head <= head_nx;
                  cnt  <= cnt - 1'b1;
               end
               else if (net_up && (first_tx || cnt != '0) && !tx_valid_out)
               begin
                  tx_overhead_out <= ovh;
                  new_ready_out   <= 1'b0;
                  tx_valid_out    <= 1'b1;
                  if (first_tx)
                  begin
                     tx_data_out <= '0;
                     tx_prio_out <= ppq_pkg::PRIO_RESET;
                  end
                  else
                  begin
                     tx_data_out <= data_mem[head];
                     tx_prio_out <= prio_mem[head];
                  end
                  state <= ppq_pkg::PPQ_SEND;
               end
               else
               begin
                  new_ready_out <= pwr_done && !ins_go;
               end
            end
            ppq_pkg::PPQ_EVICT:
            begin
               evict_acc <= acc_nx;
               if (fits_after && acc_nx != '0)
               begin
                  probe <= head; // Second pass erases the planned span
                  state <= ppq_pkg::PPQ_SEND;
                  tx_valid_out <= 1'b0;
               end
               else if (probe_end || cnt == '0)
               begin
                  ins_go <= 1'b0;
                  new_dropped_out <= 1'b1;
                  state <= commit ? ppq_pkg::PPQ_PUP : (pwr_done ? ppq_pkg::PPQ_IDLE : ppq_pkg::PPQ_SCAN);
               end
               else probe <= probe_nx;
            end
            ppq_pkg::PPQ_SEND:
            begin
               if (ins_go)
               begin
                  // Erase oldest eligible packets until the plan is spent
                  if (probe_hit && evict_acc != '0)
                  begin
                     live_mem[probe] <= 1'b0;
                     used      <= used - probe_cost;
                     evict_acc <= (evict_acc > probe_cost) ? evict_acc - probe_cost : '0;
                  end
                  if (evict_acc == '0 || (probe_hit && evict_acc <= probe_cost)) state <= ppq_pkg::PPQ_IDLE;
                  probe <= probe_nx;
               end
               else if (tx_ready_in)
               begin
                  tx_valid_out <= 1'b0;
                  if (first_tx) first_tx <= 1'b0;
                  else
                  begin
                     live_mem[head] <= 1'b0;
                     used <= used - (evt_mem[head] ? CW'(ppq_pkg::EVENT_COST) : CW'(ppq_pkg::REPORT_COST));
                     head <= head_nx;
                     cnt  <= cnt - 1'b1;
                  end
                  state <= ppq_pkg::PPQ_IDLE;
               end
            end
            default: state <= ppq_pkg::PPQ_IDLE;
         endcase
      end
   end

   // Power-up sequence finished once the power-up event is staged in PPQ_PUP, or once the scan closed with power events disabled
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in) pwr_done <= 1'b0;
      else if (state == ppq_pkg::PPQ_PUP) pwr_done <= 1'b1;
      else if (state == ppq_pkg::PPQ_IDLE && !ins_go && !commit && scan_done_in && !pwr_events_en_in)
         pwr_done <= 1'b1;
   end
endmodule : ppq_queue
`default_nettype wire

// ==== design/ppq_top.sv ====
// Top: queue followed by the 8-word output FIFO toward the modem path.
// Assumes modem path consumes with valid/ready on clk_in.
`default_nettype none
module ppq_top (
   input  wire logic                        clk_in,
   input  wire logic                        sys_rst_in,
   input  wire logic                        pwr_events_en_in,
   input  wire logic [31:0]                 last_sat_time_in,
   input  wire logic [31:0]                 rtc_time_in,
   input  wire logic                        scan_valid_in,
   input  wire logic                        scan_done_in,
   input  wire logic [31:0]                 scan_data_in,
   input  wire logic [3:0]                  scan_prio_in,
   input  wire logic                        scan_event_in,
   output logic                             scan_ready_out,
   input  wire logic                        new_valid_in,
   input  wire logic [31:0]                 new_data_in,
   input  wire logic [3:0]                  new_prio_in,
   input  wire logic                        new_event_in,
   output logic                             new_ready_out,
   output logic                             new_dropped_out,
   input  wire logic [1:0]                  net_in,
   input  wire logic                        buffer_net_in,
   output logic [41:0]                      modem_data_out,
   output logic                             modem_valid_out,
   input  wire logic                        modem_ready_in,
   output logic [11:0]                      used_out
);
   logic [31:0] q_data;
   logic [3:0]  q_prio;
   logic [5:0]  q_ovh;
   logic        q_valid;
   logic        f_ready;
   ppq_queue u_queue (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pwr_events_en_in(pwr_events_en_in),
      .last_sat_time_in(last_sat_time_in), .rtc_time_in(rtc_time_in),
      .scan_valid_in(scan_valid_in), .scan_done_in(scan_done_in), .scan_data_in(scan_data_in),
      .scan_prio_in(scan_prio_in), .scan_event_in(scan_event_in), .scan_ready_out(scan_ready_out),
      .new_valid_in(new_valid_in), .new_data_in(new_data_in), .new_prio_in(new_prio_in),
      .new_event_in(new_event_in), .new_ready_out(new_ready_out), .new_dropped_out(new_dropped_out),
      .net_in(net_in), .buffer_net_in(buffer_net_in),
      .tx_data_out(q_data), .tx_prio_out(q_prio), .tx_overhead_out(q_ovh),
      .tx_valid_out(q_valid), .tx_ready_in(f_ready), .used_out(used_out));
   ppq_fifo #(.W(42), .D(ppq_pkg::FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .in_data_in({q_ovh, q_prio, q_data}), .in_valid_in(q_valid), .in_ready_out(f_ready),
      .out_data_out(modem_data_out), .out_valid_out(modem_valid_out), .out_ready_in(modem_ready_in));
endmodule : ppq_top
`default_nettype wire

// ==== dv/ppq_modem_model.sv ====
// Modem path model: takes words from the output FIFO, promptly or slowly.
// Assumes the bench drives slow_in and reads the got queue.
`default_nettype none
module ppq_modem_model (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [41:0] data_in,
   input  wire logic        valid_in,
   input  wire logic        slow_in,
   output var  logic        ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [41:0] got[$];
   int unsigned cnt = 0;
   initial ready_out = 1'b0;
   // Slow mode accepts one word in three cycles
   always @(negedge clk_in)
   begin
      cnt++;
      ready_out <= !sys_rst_in && (!slow_in || (cnt % 3) == 0);
   end
   always @(posedge clk_in)
      if (!sys_rst_in && valid_in === 1'b1 && ready_out === 1'b1)
         got.push_back(data_in);
endmodule : ppq_modem_model
`default_nettype wire

// ==== dv/ppq_top_asserts.sv ====
// Port checker for ppq_top.
// Assumes one clock domain; bound to every ppq_top instance.
`default_nettype none
module ppq_top_asserts (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        scan_valid_in,
   input wire logic        scan_done_in,
   input wire logic        scan_ready_out,
   input wire logic        new_valid_in,
   input wire logic        new_event_in,
   input wire logic        new_ready_out,
   input wire logic        new_dropped_out,
   input wire logic [1:0]  net_in,
   input wire logic        buffer_net_in,
   input wire logic [41:0] modem_data_out,
   input wire logic        modem_valid_out,
   input wire logic        modem_ready_in,
   input wire logic [11:0] used_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       scan_over;
   logic [4:0] idle_cnt;
   logic       held;
   assign held = (net_in == ppq_pkg::NET_NONE) || buffer_net_in;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         scan_over <= 1'b0;
      else if (scan_done_in)
         scan_over <= 1'b1;
   // Cycles spent held with the modem ready
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
         idle_cnt <= 5'h00;
      else if (!held || !modem_ready_in)
         idle_cnt <= 5'h00;
      else if (idle_cnt != 5'h10)
         idle_cnt <= idle_cnt + 5'h01;
   modem_hold_a: assert property (modem_valid_out && !modem_ready_in |=> modem_valid_out && $stable(modem_data_out))
      else $error("modem word changed before taken");
   overhead_code_a: assert property (modem_valid_out |-> modem_data_out[41:36] inside {6'h1F, 6'h03, 6'h00})
      else $error("bad overhead field");
   prio_code_a: assert property (modem_valid_out |-> modem_data_out[35:32] <= 4'h8 || modem_data_out[35:32] == 4'hA)
      else $error("bad priority field");
   used_cap_a: assert property (used_out <= 12'h7D0)
      else $error("usage above capacity");
   scan_first_a: assert property (!scan_over |-> !new_ready_out)
      else $error("new packet accepted during rebuild");
   drop_pulse_a: assert property (new_dropped_out |=> !new_dropped_out)
      else $error("drop pulse too long");
   drop_keep_a: assert property (new_dropped_out && held |-> used_out == $past(used_out))
      else $error("drop changed contents");
   held_idle_a: assert property (idle_cnt == 5'h10 |-> !modem_valid_out)
      else $error("word sent while held");
   used_grow_a: assert property (new_valid_in && new_ready_out && !new_event_in && held && used_out < 12'h7D0
      |-> ##[1:3] used_out > $past(used_out, 3))
      else $error("report not counted");
   drop_seen_c: cover property (new_dropped_out);
   modem_take_c: cover property (modem_valid_out && modem_ready_in);
   scan_take_c: cover property (scan_valid_in && scan_ready_out);
endmodule : ppq_top_asserts
bind ppq_top ppq_top_asserts i_ppq_top_asserts (.clk_in, .sys_rst_in, .scan_valid_in, .scan_done_in,
   .scan_ready_out, .new_valid_in, .new_event_in, .new_ready_out, .new_dropped_out, .net_in, .buffer_net_in,
   .modem_data_out, .modem_valid_out, .modem_ready_in, .used_out);
`default_nettype wire

// ==== dv/ppq_top_tb.sv ====
// Bench for ppq_top: rebuild, holding, drain framing, fill and eviction.
// Assumes ppq_modem_model as far side and the bound checker.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module ppq_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0, sys_rst_in = 1'b1, pwr_events_en_in = 1'b1;
   logic [31:0] last_sat_time_in = 32'h5A5A0001, rtc_time_in = 32'h5A5A0002;
   logic        scan_valid_in = 1'b0, scan_done_in = 1'b0, scan_event_in = 1'b0;
   logic        new_valid_in = 1'b0, new_event_in = 1'b0, buffer_net_in = 1'b0, slow = 1'b0;
   logic [31:0] scan_data_in = 32'h0, new_data_in = 32'h0;
   logic [3:0]  scan_prio_in = 4'h0, new_prio_in = 4'h0;
   logic [1:0]  net_in = ppq_pkg::NET_NONE;
   logic        scan_ready_out, new_ready_out, new_dropped_out, modem_valid_out, modem_ready_in;
   logic [41:0] modem_data_out;
   logic [11:0] used_out;
   int          n_fail = 0, n_checks = 0, n_drop = 0, cyc = 0;
   ppq_top i_ppq_top (.clk_in, .sys_rst_in, .pwr_events_en_in, .last_sat_time_in, .rtc_time_in, .scan_valid_in,
      .scan_done_in, .scan_data_in, .scan_prio_in, .scan_event_in, .scan_ready_out, .new_valid_in, .new_data_in,
      .new_prio_in, .new_event_in, .new_ready_out, .new_dropped_out, .net_in, .buffer_net_in, .modem_data_out,
      .modem_valid_out, .modem_ready_in, .used_out);
   ppq_modem_model i_ppq_modem_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .data_in(modem_data_out),
      .valid_in(modem_valid_out), .slow_in(slow), .ready_out(modem_ready_in));
   always #4 clk_in = !clk_in;
   always @(posedge clk_in)
      if (new_dropped_out === 1'b1)
         n_drop++;
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic put(input bit scan, input logic [31:0] d, input logic [3:0] p, input logic ev);
      int n;
      @(negedge clk_in);
      scan_data_in = d;
      new_data_in = d;
      scan_prio_in = p;
      new_prio_in = p;
      scan_event_in = ev;
      new_event_in = ev;
      scan_valid_in = scan;
      new_valid_in = !scan;
      n = 0;
      while ((scan ? scan_ready_out : new_ready_out) !== 1'b1 && n < 5000)
      begin
         @(negedge clk_in);
         n++;
      end
      `CHK("taken", 1'b1, n < 5000)
      @(negedge clk_in);
      scan_valid_in = 1'b0;
      new_valid_in = 1'b0;
   endtask : put
   task automatic wait_used(input logic [11:0] e);
      int n;
      n = 0;
      while (used_out !== e && n < 4000)
      begin
         @(negedge clk_in);
         n++;
      end
      `CHK("used", e, used_out)
   endtask : wait_used
   task automatic expect_word(input logic [31:0] d, input logic [3:0] p, input logic [5:0] o, input bit use_d);
      logic [41:0] w;
      int          n;
      n = 0;
      while (i_ppq_modem_model.got.size() == 0 && n < 4000)
      begin
         @(negedge clk_in);
         n++;
      end
      w = (n < 4000) ? i_ppq_modem_model.got.pop_front() : 42'h0;
      `CHK("overhead", o, w[41:36])
      `CHK("prio", p, w[35:32])
      if (use_d)
         `CHK("data", d, w[31:0])
   endtask : expect_word
   task automatic rebuild();
      put(1, 32'h00000011, ppq_pkg::PRIO_POS, 1'b0);
      put(1, 32'h00000022, ppq_pkg::PRIO_WAYPOINT, 1'b1);
      scan_done_in = 1'b1;
      wait_used(12'h01F);
   endtask : rebuild
   task automatic hold_back();
      put(0, 32'h00000033, ppq_pkg::PRIO_STATUS, 1'b0);
      wait_used(12'h020);
      repeat (50) @(negedge clk_in);
      `CHK("no net sent", 0, i_ppq_modem_model.got.size())
      net_in = ppq_pkg::NET_CELL;
      buffer_net_in = 1'b1;
      repeat (50) @(negedge clk_in);
      `CHK("buffered sent", 0, i_ppq_modem_model.got.size())
   endtask : hold_back
   task automatic drain_cell();
      slow = 1'b1;
      buffer_net_in = 1'b0;
      expect_word(32'h0, ppq_pkg::PRIO_RESET, 6'h1F, 0);
      expect_word(32'h00000011, ppq_pkg::PRIO_POS, 6'h1F, 1);
      expect_word(32'h00000022, ppq_pkg::PRIO_WAYPOINT, 6'h1F, 1);
      expect_word(last_sat_time_in, ppq_pkg::PRIO_POWER, 6'h1F, 1);
      expect_word(rtc_time_in, ppq_pkg::PRIO_POWER, 6'h1F, 1);
      expect_word(32'h00000033, ppq_pkg::PRIO_STATUS, 6'h1F, 1);
      wait_used(12'h000);
      slow = 1'b0;
   endtask : drain_cell
   task automatic other_nets();
      net_in = ppq_pkg::NET_RF;
      put(0, 32'h00000044, ppq_pkg::PRIO_POS_TERR, 1'b0);
      expect_word(32'h00000044, ppq_pkg::PRIO_POS_TERR, 6'h03, 1);
      net_in = ppq_pkg::NET_SAT;
      put(0, 32'h00000055, ppq_pkg::PRIO_SERVER, 1'b0);
      expect_word(32'h00000055, ppq_pkg::PRIO_SERVER, 6'h00, 1);
      net_in = ppq_pkg::NET_NONE;
   endtask : other_nets
   task automatic fill_evict();
      int n;
      for (int i = 0; i < 2000; i++)
         put(0, 32'(i), ppq_pkg::PRIO_POS, 1'b0);
      wait_used(12'h7D0);
      put(0, 32'h0000AAAA, ppq_pkg::PRIO_POS, 1'b0);
      wait_used(12'h7D0);
      put(0, 32'h0000BBBB, ppq_pkg::PRIO_POS_TERR, 1'b0);
      n = 0;
      while (n_drop == 0 && n < 4000)
      begin
         @(negedge clk_in);
         n++;
      end
      `CHK("dropped", 1, n_drop)
      put(0, 32'h0000CCCC, ppq_pkg::PRIO_POWER, 1'b1);
      put(0, 32'h0000DDDD, ppq_pkg::PRIO_RESET, 1'b0);
      repeat (40) @(negedge clk_in);
      `CHK("no extra drop", 1, n_drop)
      net_in = ppq_pkg::NET_SAT;
      expect_word(32'd12, ppq_pkg::PRIO_POS, 6'h00, 1);
   endtask : fill_evict
   initial
   begin
      repeat (16) @(negedge clk_in);
      sys_rst_in = 1'b0;
      rebuild();
      hold_back();
      drain_cell();
      other_nets();
      fill_evict();
      stop_test();
   end
endmodule : ppq_top_tb
`default_nettype wire
